//--- design/iscd_params.svh
// offsets, field positions, reset values and timing of the source classifier
// How it works
// - classify only after power good is seen
// - classification starts only while auto enable set
// - bc done sets status, flag, interrupt pulse
// - dedicated port plus enable starts handshake
// - result writes limit and source type
// - enforce lower of register and pin limit
// - auto disabled leaves limit untouched
// - stages: contact, primary, secondary, high voltage
// - secondary split first, then divider, then standard
// - sdp, cdp, dcp codes and limits
// - high voltage and unknown codes, limits
// - divider adapters share one code, four limits
// - twelve volt tried first when both set
// - done clears busy, flags, pulses interrupt
// - dcp limit first, lowered after handshake
// - host selects line drive levels
// - level writes ignored while classifying
// - pair presence caught at power on
// - driver on only when all conditions hold
// - both drivers shorted locks paths off
`ifndef ISCD_PARAMS_SVH
`define ISCD_PARAMS_SVH
`define ISCD_CLK_MHZ 10
`define ISCD_STEP_US 20
`define ISCD_STEP_CYC (`ISCD_STEP_US * `ISCD_CLK_MHZ)
`define ISCD_HV_US 200
`define ISCD_HV_CYC (`ISCD_HV_US * `ISCD_CLK_MHZ)
`define ISCD_A_CTRL 4'h0
`define ISCD_A_ILIM 4'h1
`define ISCD_A_STAT 4'h2
`define ISCD_A_FLAG 4'h3
`define ISCD_A_MASK 4'h4
`define ISCD_A_LVL 4'h5
`define ISCD_A_PATH 4'h6
`define ISCD_A_EFF 4'h7
`define ISCD_C_AUTO 0
`define ISCD_C_HVEN 1
`define ISCD_C_NINE 2
`define ISCD_C_TWELVE 3
`define ISCD_C_EXTLIM 4
`define ISCD_C_HIZ 5
`define ISCD_C_OFFBOTH 6
`define ISCD_C_OFF 7
`define ISCD_CTRL_RST 8'h11
`define ISCD_ILIM_RST 12'h12c
`define ISCD_LIM_SDP 12'h032
`define ISCD_LIM_CDP 12'h096
`define ISCD_LIM_DCP 12'h145
`define ISCD_LIM_HV 12'h096
`define ISCD_LIM_UNK 12'h12c
`define ISCD_LIM_DIV1 12'h0d2
`define ISCD_LIM_DIV2 12'h0c8
`define ISCD_LIM_DIV3 12'h064
`define ISCD_LIM_DIV4 12'h0f0
`endif

//--- design/iscd_pkg.sv
// types of the source classifier
`default_nettype none
package iscd_pkg;
  typedef enum logic [2:0] {
    ISCD_IDLE = 3'b000,
    ISCD_CONTACT = 3'b001,
    ISCD_PRIMARY = 3'b010,
    ISCD_SECONDARY = 3'b011,
    ISCD_HIGHV = 3'b100,
    ISCD_DONE = 3'b101
  } iscd_state_t;
  typedef enum logic [3:0] {
    ISCD_SRC_NONE = 4'h0,
    ISCD_SRC_SDP = 4'h1,
    ISCD_SRC_CDP = 4'h2,
    ISCD_SRC_DCP = 4'h3,
    ISCD_SRC_HV = 4'h4,
    ISCD_SRC_UNK = 4'h5,
    ISCD_SRC_DIV = 4'h6
  } iscd_src_t;
endpackage : iscd_pkg
`default_nettype wire

//--- design/iscd_step_timer.sv
// stage timer: reloads on request, pulses once when the count runs out
`timescale 1ns/1ps
`default_nettype none
module iscd_step_timer #(
  parameter int W = 12
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic load, // restart with len
  input wire logic [W-1:0] len, // cycles to run
  output logic expire // one-cycle pulse
);
  logic [W-1:0] cnt_ff;
  logic run_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        cnt_ff <= len;
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (cnt_ff <= W'(1)) begin
          run_ff <= 1'b0;
          expire <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - W'(1);
        end
      end
    end
  end
endmodule : iscd_step_timer
`default_nettype wire

//--- design/iscd_top.sv
// source classifier, input current limit and power-path driver control
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "iscd_params.svh"
module iscd_top
  import iscd_pkg::*;
#(
  parameter int STEP_CYC = `ISCD_STEP_CYC,
  parameter int HV_CYC = `ISCD_HV_CYC
) (
  input wire logic MCLK, // core clock
  input wire logic RESETN, // async reset, active low
  input wire logic [3:0] ADDR, // register address
  input wire logic [15:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [15:0] RDATA, // read data, cycle after RD
  input wire logic POWER_GOOD, // source qualified
  input wire logic DATA_CONTACT, // data lines made contact
  input wire logic PRIMARY_CHG, // primary sees a charging port
  input wire logic SECONDARY_DCP, // secondary sees a dedicated port
  input wire logic [2:0] DIVIDER_ID, // divider adapter 1..4, 0 none
  input wire logic HV_ACK, // adapter accepted raised voltage
  input wire logic [11:0] PIN_LIMIT, // limit from limit_pin, 10 mA
  input wire logic PATH1_SHORT, // path1_driver pin grounded
  input wire logic PATH2_SHORT, // path2_driver pin grounded
  input wire logic IN1_PRESENT, // input_one_sense above present
  input wire logic IN1_OVP, // input_one_sense over voltage
  input wire logic IN2_PRESENT, // input_two_sense above present
  input wire logic IN2_OVP, // input_two_sense over voltage
  input wire logic VBUS_PRESENT, // bus above present
  output logic INT_N, // interrupt pulse, active low
  output logic [2:0] DP_LEVEL, // dplus_level_select
  output logic [2:0] DM_LEVEL, // dminus_level_select
  output logic LINE_DRIVE_EN, // host drive on data lines
  output logic HV_REQ_NINE, // request nine volts
  output logic HV_REQ_TWELVE, // request twelve volts
  output logic PATH1_DRV, // path1_driver
  output logic PATH2_DRV, // path2_driver
  output logic [11:0] LIMIT_OUT // enforced input current limit
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  iscd_state_t state_ff, nxt_state;
  logic [7:0] ctrl_ff;
  logic [11:0] ilim_ff, res_lim, tmr_len;
  iscd_src_t src_ff, res_type;
  logic busy_ff, bc_stat_ff, bc_flag_ff, line_flag_ff;
  logic [1:0] mask_ff, path_en_ff;
  logic pg_q_ff, contact_ff, try12_ff, nxt_try12;
  logic det1_ff, det2_ff, both_short_ff, por_done_ff;
  logic tmr_load, tmr_exp, res_we, bc_evt, end_evt, retry_nine;
  logic pg_rise, wr_ctrl, wr_lvl, wr_path, rd_flag;
  logic ok1, ok2, bc_irq, line_irq;

  function automatic logic [11:0] lim_min(input logic [11:0] a, input logic [11:0] b);
    lim_min = (a < b) ? a : b;
  endfunction : lim_min

  function automatic logic [11:0] div_limit(input logic [2:0] id);
    unique case (id)
      3'h1: div_limit = `ISCD_LIM_DIV1;
      3'h2: div_limit = `ISCD_LIM_DIV2;
      3'h3: div_limit = `ISCD_LIM_DIV3;
      default: div_limit = `ISCD_LIM_DIV4;
    endcase
  endfunction : div_limit

  assign pg_rise = POWER_GOOD && !pg_q_ff;
  assign wr_ctrl = WR && (ADDR == `ISCD_A_CTRL);
  assign wr_lvl = WR && (ADDR == `ISCD_A_LVL);
  assign wr_path = WR && (ADDR == `ISCD_A_PATH);
  assign rd_flag = RD && (ADDR == `ISCD_A_FLAG);
  assign bc_irq = bc_evt && !mask_ff[0];
  assign line_irq = end_evt && !mask_ff[1];

  iscd_step_timer #(
    .W(12)
  ) u_timer (
    .clk(MCLK),
    .rst_n(RESETN),
    .load(tmr_load),
    .len(tmr_len),
    .expire(tmr_exp)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_try12 = try12_ff;
    tmr_load = 1'b0;
    tmr_len = 12'(STEP_CYC);
    res_we = 1'b0;
    res_type = src_ff;
    res_lim = ilim_ff;
    bc_evt = 1'b0;
    end_evt = 1'b0;
    retry_nine = 1'b0;
    unique case (state_ff)
      ISCD_IDLE: begin
        // only with auto enable; otherwise nothing changes
        if (pg_rise && ctrl_ff[`ISCD_C_AUTO]) begin
          nxt_state = ISCD_CONTACT;
          tmr_load = 1'b1;
        end
      end
      ISCD_CONTACT: begin
        if (tmr_exp || DATA_CONTACT) begin
          nxt_state = ISCD_PRIMARY;
          tmr_load = 1'b1;
        end
      end
      ISCD_PRIMARY: begin
        if (tmr_exp) begin
          res_we = !PRIMARY_CHG;
          bc_evt = !PRIMARY_CHG;
          // charging port first, then divider check, standard result last
          if (PRIMARY_CHG) begin
            nxt_state = ISCD_SECONDARY;
            tmr_load = 1'b1;
          end else if (DIVIDER_ID >= 3'h1 && DIVIDER_ID <= 3'h4) begin
            nxt_state = ISCD_DONE;
            res_type = ISCD_SRC_DIV;
            res_lim = div_limit(DIVIDER_ID);
          end else if (!contact_ff) begin
            nxt_state = ISCD_DONE;
            res_type = ISCD_SRC_UNK;
            res_lim = `ISCD_LIM_UNK;
          end else begin
            nxt_state = ISCD_DONE;
            res_type = ISCD_SRC_SDP;
            res_lim = `ISCD_LIM_SDP;
          end
        end
      end
      ISCD_SECONDARY: begin
        if (tmr_exp) begin
          res_we = 1'b1;
          bc_evt = 1'b1;
          nxt_state = ISCD_DONE;
          if (SECONDARY_DCP) begin
            res_type = ISCD_SRC_DCP;
            res_lim = `ISCD_LIM_DCP;
            if (ctrl_ff[`ISCD_C_HVEN] &&
                (ctrl_ff[`ISCD_C_NINE] || ctrl_ff[`ISCD_C_TWELVE])) begin
              nxt_state = ISCD_HIGHV;
              tmr_load = 1'b1;
              tmr_len = 12'(HV_CYC);
              nxt_try12 = ctrl_ff[`ISCD_C_TWELVE];
            end
          end else begin
            res_type = ISCD_SRC_CDP;
            res_lim = `ISCD_LIM_CDP;
          end
        end
      end
      ISCD_HIGHV: begin
        if (HV_ACK) begin
          // lowered once handshake completes; its code
          nxt_state = ISCD_DONE;
          res_we = 1'b1;
          res_type = ISCD_SRC_HV;
          res_lim = `ISCD_LIM_HV;
        end else if (tmr_exp) begin
          if (try12_ff && ctrl_ff[`ISCD_C_NINE]) begin
            retry_nine = 1'b1;
            nxt_try12 = 1'b0;
            tmr_load = 1'b1;
            tmr_len = 12'(HV_CYC);
          end else begin
            nxt_state = ISCD_DONE;
          end
        end
      end
      ISCD_DONE: begin
        end_evt = 1'b1;
        nxt_state = ISCD_IDLE;
      end
      default: nxt_state = ISCD_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= ISCD_IDLE;
      try12_ff <= 1'b0;
      pg_q_ff <= 1'b0;
      contact_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      try12_ff <= nxt_try12;
      pg_q_ff <= POWER_GOOD;
      if (state_ff == ISCD_IDLE) begin
        contact_ff <= 1'b0;
      end else if (state_ff == ISCD_CONTACT && DATA_CONTACT) begin
        contact_ff <= 1'b1;
      end
    end
  end

  // raised-voltage requests follow the handshake state
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      HV_REQ_NINE <= 1'b0;
      HV_REQ_TWELVE <= 1'b0;
    end else begin
      HV_REQ_TWELVE <= (nxt_state == ISCD_HIGHV) && nxt_try12;
      HV_REQ_NINE <= (nxt_state == ISCD_HIGHV) && !nxt_try12;
    end
  end

  // result written when a stage ends in a source type; device update wins
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ilim_ff <= `ISCD_ILIM_RST;
      src_ff <= ISCD_SRC_NONE;
    end else if (res_we) begin
      ilim_ff <= res_lim;
      src_ff <= res_type;
    end else if (WR && ADDR == `ISCD_A_ILIM) begin
      ilim_ff <= WDATA[11:0];
    end
  end

  // enforce the lower limit when the pin clamp is on
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      LIMIT_OUT <= `ISCD_ILIM_RST;
    end else if (ctrl_ff[`ISCD_C_EXTLIM]) begin
      LIMIT_OUT <= lim_min(ilim_ff, PIN_LIMIT);
    end else begin
      LIMIT_OUT <= ilim_ff;
    end
  end

  // status, flags and interrupt; a set beats a read clear
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      busy_ff <= 1'b0;
      bc_stat_ff <= 1'b0;
      bc_flag_ff <= 1'b0;
      line_flag_ff <= 1'b0;
      INT_N <= 1'b1;
    end else begin
      if (state_ff == ISCD_IDLE && nxt_state == ISCD_CONTACT) begin
        busy_ff <= 1'b1;
        bc_stat_ff <= 1'b0;
      end else if (end_evt) begin
        busy_ff <= 1'b0;
      end
      if (bc_evt) begin
        bc_stat_ff <= 1'b1;
      end
      if (bc_irq) begin
        bc_flag_ff <= 1'b1;
      end else if (rd_flag) begin
        bc_flag_ff <= 1'b0;
      end
      if (line_irq) begin
        line_flag_ff <= 1'b1;
      end else if (rd_flag) begin
        line_flag_ff <= 1'b0;
      end
      INT_N <= !(bc_irq || line_irq);
    end
  end

  // control register; a double short forces the paths off
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_ff <= `ISCD_CTRL_RST;
      mask_ff <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= WDATA[7:0];
      end
      // force-off set when both drivers are grounded on the first edge after reset
      if (!por_done_ff && PATH1_SHORT && PATH2_SHORT) begin
        ctrl_ff[`ISCD_C_OFF] <= 1'b1;
      end
      if (WR && ADDR == `ISCD_A_MASK) begin
        mask_ff <= WDATA[1:0];
      end
    end
  end

  // host level selects; frozen during classification
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      DP_LEVEL <= 3'h0;
      DM_LEVEL <= 3'h0;
      LINE_DRIVE_EN <= 1'b0;
    end else begin
      if (wr_lvl && !busy_ff) begin
        DP_LEVEL <= WDATA[2:0];
        DM_LEVEL <= WDATA[6:4];
      end
      // drive only on the first input
      LINE_DRIVE_EN <= IN1_PRESENT && !busy_ff &&
                       ((DP_LEVEL != 3'h0) || (DM_LEVEL != 3'h0));
    end
  end

  // pair presence caught on the first edge after reset release
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      por_done_ff <= 1'b0;
      det1_ff <= 1'b0;
      det2_ff <= 1'b0;
      both_short_ff <= 1'b0;
    end else if (!por_done_ff) begin
      por_done_ff <= 1'b1;
      det1_ff <= !PATH1_SHORT;
      det2_ff <= !PATH2_SHORT;
      both_short_ff <= PATH1_SHORT && PATH2_SHORT;
    end
  end

  // path enables; both on at once is refused, a double short locks them at zero
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      path_en_ff <= 2'h0;
    end else if (both_short_ff) begin
      path_en_ff <= 2'h0;
    end else if (wr_path && WDATA[1:0] != 2'h3) begin
      path_en_ff <= WDATA[1:0];
    end
  end

  // every turn-on condition; once on, the bus being present is expected
  assign ok1 = det1_ff && path_en_ff[0] && IN1_PRESENT && !IN1_OVP &&
               !ctrl_ff[`ISCD_C_OFFBOTH] && !ctrl_ff[`ISCD_C_HIZ] &&
               !ctrl_ff[`ISCD_C_OFF];
  assign ok2 = det2_ff && path_en_ff[1] && IN2_PRESENT && !IN2_OVP &&
               !ctrl_ff[`ISCD_C_OFFBOTH] && !ctrl_ff[`ISCD_C_HIZ] &&
               !ctrl_ff[`ISCD_C_OFF];

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      PATH1_DRV <= 1'b0;
      PATH2_DRV <= 1'b0;
    end else begin
      PATH1_DRV <= ok1 && (PATH1_DRV || (!VBUS_PRESENT && !PATH2_DRV));
      PATH2_DRV <= ok2 && (PATH2_DRV || (!VBUS_PRESENT && !PATH1_DRV));
    end
  end

  // read data stand only in the cycle after RD
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      unique case (ADDR)
        `ISCD_A_CTRL: RDATA <= {8'h00, ctrl_ff};
        `ISCD_A_ILIM: RDATA <= {4'h0, ilim_ff};
        `ISCD_A_STAT: RDATA <= {7'h00, det2_ff, det1_ff, POWER_GOOD, bc_stat_ff,
                                busy_ff, src_ff};
        `ISCD_A_FLAG: RDATA <= {14'h0000, line_flag_ff, bc_flag_ff};
        `ISCD_A_MASK: RDATA <= {14'h0000, mask_ff};
        `ISCD_A_LVL: RDATA <= {9'h000, DM_LEVEL, 1'b0, DP_LEVEL};
        `ISCD_A_PATH: RDATA <= {14'h0000, path_en_ff};
        `ISCD_A_EFF: RDATA <= {4'h0, LIMIT_OUT};
        default: RDATA <= 16'h0000;
      endcase
    end else begin
      RDATA <= 16'h0000;
    end
  end

  sequence s_dcp_found;
    state_ff == ISCD_SECONDARY && tmr_exp && SECONDARY_DCP;
  endsequence

  sequence s_hv_allowed;
    ctrl_ff[`ISCD_C_HVEN] && ctrl_ff[`ISCD_C_TWELVE];
  endsequence

  a_start_after_pg: assert property (
    $rose(busy_ff) |-> $past(POWER_GOOD) && !$past(pg_q_ff))
    else $error("classification began without power good");
  a_auto_gate: assert property (
    state_ff == ISCD_IDLE && !ctrl_ff[`ISCD_C_AUTO] |=> !$rose(busy_ff))
    else $error("classification ran with auto disabled");
  a_bc_done_irq: assert property (
    bc_evt && !mask_ff[0] |=> bc_stat_ff && bc_flag_ff && !INT_N)
    else $error("bc done not signalled");
  a_hv_start: assert property (
    (s_dcp_found and s_hv_allowed) |=> state_ff == ISCD_HIGHV && HV_REQ_TWELVE)
    else $error("handshake did not start at twelve volts");
  a_result_write: assert property (
    res_we |=> ilim_ff == $past(res_lim) && src_ff == $past(res_type))
    else $error("result not written");
  a_limit_clamp: assert property (
    ctrl_ff[`ISCD_C_EXTLIM] && PIN_LIMIT < ilim_ff |=> LIMIT_OUT == $past(PIN_LIMIT))
    else $error("pin limit not enforced");
  a_stage_order: assert property (
    $past(state_ff) == ISCD_CONTACT && state_ff != ISCD_CONTACT |-> state_ff == ISCD_PRIMARY)
    else $error("contact detect not followed by primary");
  a_busy_done: assert property (
    end_evt && !mask_ff[1] |=> !busy_ff && line_flag_ff && !INT_N ##1 INT_N)
    else $error("done not signalled");
  a_level_lock: assert property (
    wr_lvl && busy_ff |=> DP_LEVEL == $past(DP_LEVEL) && DM_LEVEL == $past(DM_LEVEL))
    else $error("level write taken while busy");
  a_drv_turn_on: assert property (
    $rose(PATH1_DRV) |-> !$past(VBUS_PRESENT) && $past(IN1_PRESENT) && !$past(IN1_OVP) &&
                         $past(det1_ff))
    else $error("path1 driver on without its conditions");
  a_short_lock: assert property (
    both_short_ff |-> !PATH1_DRV && !PATH2_DRV && path_en_ff == 2'h0 && !det1_ff)
    else $error("shorted paths not locked off");
endmodule : iscd_top
`default_nettype wire

//--- testbench/iscd_adapter_model.sv
// behavioural charging adapter as seen on the data lines
`timescale 1ns/1ps
`default_nettype none
module iscd_adapter_model (
  input wire logic [2:0] kind, // 0 sdp 1 cdp 2 dcp 3 unknown 4..7 divider 1..4
  input wire logic acc_nine, // adapter accepts nine volts
  input wire logic acc_twelve, // adapter accepts twelve volts
  input wire logic req_nine, // charger asks for nine volts
  input wire logic req_twelve, // charger asks for twelve volts
  output logic contact, // data contact made
  output logic prim_chg, // primary sees a charging port
  output logic sec_dcp, // secondary sees a dedicated port
  output logic [2:0] div_id, // divider number, 0 none
  output logic ack // raised voltage accepted
);
  // an unknown adapter never shows contact, so that stage must time out
  assign contact = (kind != 3'h3);
  assign prim_chg = (kind == 3'h1) || (kind == 3'h2);
  assign sec_dcp = (kind == 3'h2);
  assign div_id = kind[2] ? (kind - 3'h3) : 3'h0;
  // no enumeration sent
  // runs are far shorter than the port's enumeration window, so it never reverts
  assign ack = (req_nine && acc_nine) || (req_twelve && acc_twelve);
endmodule : iscd_adapter_model
`default_nettype wire

//--- testbench/tb_iscd_top.sv
// self-checking testbench of the source classifier
`timescale 1ns/1ps
`default_nettype none
`include "iscd_params.svh"
module tb_iscd_top
  import iscd_pkg::*;
;
  logic mclk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, pg = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, rv;
  logic [2:0] kind = 3'h0, div, dp_lvl, dm_lvl;
  logic acc9 = 1'b0, acc12 = 1'b0, sh1 = 1'b0, sh2 = 1'b0, in1 = 1'b0, ovp1 = 1'b0;
  logic in2 = 1'b0, ovp2 = 1'b0, vbus = 1'b0;
  logic [11:0] pin_lim = 12'hfff, lim_out;
  logic contact, prim, sec, ack, int_n, drive_en, req9, req12, drv1, drv2;
  int fails = 0, n_tests = 0, n_int = 0, nb = 0, first_req = 0;
  logic [3:0] exp_t [8] = '{ISCD_SRC_SDP, ISCD_SRC_CDP, ISCD_SRC_DCP, ISCD_SRC_UNK,
    ISCD_SRC_DIV, ISCD_SRC_DIV, ISCD_SRC_DIV, ISCD_SRC_DIV};
  logic [11:0] exp_l [8] = '{`ISCD_LIM_SDP, `ISCD_LIM_CDP, `ISCD_LIM_DCP, `ISCD_LIM_UNK,
    `ISCD_LIM_DIV1, `ISCD_LIM_DIV2, `ISCD_LIM_DIV3, `ISCD_LIM_DIV4};

  always #50 mclk = ~mclk;

  iscd_top #(.STEP_CYC(4), .HV_CYC(8)) i_iscd_top (
    .MCLK(mclk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .POWER_GOOD(pg), .DATA_CONTACT(contact), .PRIMARY_CHG(prim),
    .SECONDARY_DCP(sec), .DIVIDER_ID(div), .HV_ACK(ack), .PIN_LIMIT(pin_lim),
    .PATH1_SHORT(sh1), .PATH2_SHORT(sh2), .IN1_PRESENT(in1), .IN1_OVP(ovp1),
    .IN2_PRESENT(in2), .IN2_OVP(ovp2), .VBUS_PRESENT(vbus), .INT_N(int_n),
    .DP_LEVEL(dp_lvl), .DM_LEVEL(dm_lvl), .LINE_DRIVE_EN(drive_en), .HV_REQ_NINE(req9),
    .HV_REQ_TWELVE(req12), .PATH1_DRV(drv1), .PATH2_DRV(drv2), .LIMIT_OUT(lim_out)
  );

  iscd_adapter_model i_iscd_adapter_model (
    .kind(kind), .acc_nine(acc9), .acc_twelve(acc12), .req_nine(req9),
    .req_twelve(req12), .contact(contact), .prim_chg(prim), .sec_dcp(sec),
    .div_id(div), .ack(ack)
  );

  // interrupt pulses are one cycle long, so low cycles count pulses
  always @(posedge mclk) begin
    if (int_n === 1'b0) n_int <= n_int + 1;
    if (first_req == 0 && req12 === 1'b1) first_req <= 12;
    else if (first_req == 0 && req9 === 1'b1) first_req <= 9;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rreg

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    rreg(a);
    chk(rv, exp);
  endtask : rdc

  // plug an adapter, try a level write while busy, wait for busy to drop
  task automatic classify(input logic [2:0] k);
    int i;
    @(posedge mclk);
    pg <= 1'b0;
    kind <= k;
    nb = n_int;
    repeat (2) @(posedge mclk);
    pg <= 1'b1;
    @(posedge mclk);
    wreg(`ISCD_A_LVL, 16'h0077);
    for (i = 0; i < 100; i++) begin
      rreg(`ISCD_A_STAT);
      if (rv[4] === 1'b0) break;
    end
    if (i == 100) begin
      fails++;
      print_verdict();
    end
  endtask : classify

  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rdc(`ISCD_A_CTRL, 16'h0011);
    rdc(`ISCD_A_ILIM, 16'h012c);
    rdc(`ISCD_A_EFF, 16'h012c);
    rreg(`ISCD_A_STAT);
    chk({14'h0, rv[8:7]}, 16'h0003);
    // handshake enabled with both levels, adapter refuses both
    wreg(`ISCD_A_CTRL, 16'h001f);
    for (int k = 0; k < 8; k++) begin
      classify(k[2:0]);
      rdc(`ISCD_A_LVL, 16'h0000);
      rreg(`ISCD_A_STAT);
      chk({12'h0, rv[3:0]}, {12'h0, exp_t[k]});
      chk({15'h0, rv[5]}, 16'h0001);
      rdc(`ISCD_A_ILIM, {4'h0, exp_l[k]});
      rdc(`ISCD_A_FLAG, 16'h0003);
      chk(16'(n_int - nb), 16'h0002);
    end
    chk(16'(first_req), 16'h000c);
    acc9 <= 1'b1;
    classify(3'h2);
    rreg(`ISCD_A_STAT);
    chk({12'h0, rv[3:0]}, {12'h0, ISCD_SRC_HV});
    rdc(`ISCD_A_ILIM, {4'h0, `ISCD_LIM_HV});
    rdc(`ISCD_A_FLAG, 16'h0003);
    // host drops handshake support once it has completed
    wreg(`ISCD_A_CTRL, 16'h0011);
    wreg(`ISCD_A_MASK, 16'h0003);
    classify(3'h0);
    rdc(`ISCD_A_FLAG, 16'h0000);
    chk(16'(n_int - nb), 16'h0000);
    wreg(`ISCD_A_MASK, 16'h0000);
    // auto classification off: no run, limit kept, level write lands
    wreg(`ISCD_A_CTRL, 16'h0010);
    wreg(`ISCD_A_ILIM, 16'h00aa);
    classify(3'h1);
    rdc(`ISCD_A_ILIM, 16'h00aa);
    rdc(`ISCD_A_LVL, 16'h0077);
    chk(16'(n_int - nb), 16'h0000);
    wreg(`ISCD_A_CTRL, 16'h0011);
    pin_lim <= 12'h064;
    rdc(`ISCD_A_EFF, 16'h0064);
    wreg(`ISCD_A_CTRL, 16'h0001);
    rdc(`ISCD_A_EFF, 16'h00aa);
    wreg(`ISCD_A_LVL, 16'h0052);
    rreg(`ISCD_A_LVL);
    chk({10'h0, dm_lvl, dp_lvl}, 16'h002a);
    in1 <= 1'b1;
    wreg(`ISCD_A_PATH, 16'h0001);
    repeat (3) @(posedge mclk);
    chk({14'h0, drv2, drv1}, 16'h0001);
    chk({15'h0, drive_en}, 16'h0001);
    wreg(`ISCD_A_PATH, 16'h0003);
    rdc(`ISCD_A_PATH, 16'h0001);
    wreg(`ISCD_A_CTRL, 16'h0021);
    repeat (3) @(posedge mclk);
    chk({14'h0, drv2, drv1}, 16'h0000);
    wreg(`ISCD_A_CTRL, 16'h0001);
    ovp1 <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({14'h0, drv2, drv1}, 16'h0000);
    // second reset with both driver pins grounded
    resetn <= 1'b0;
    sh1 <= 1'b1;
    sh2 <= 1'b1;
    ovp1 <= 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rreg(`ISCD_A_STAT);
    chk({14'h0, rv[8:7]}, 16'h0000);
    rdc(`ISCD_A_CTRL, 16'h0091);
    wreg(`ISCD_A_PATH, 16'h0001);
    rdc(`ISCD_A_PATH, 16'h0000);
    chk({14'h0, drv2, drv1}, 16'h0000);
    print_verdict();
  end
endmodule : tb_iscd_top
`default_nettype wire
